/* pdr_defines.vh */
// constants for the pll divider readback register bank
// assumes a byte-wide register port with 8-bit addresses
`ifndef PDR_DEFINES_VH
`define PDR_DEFINES_VH
`define PDR_OFS_P       8'h60
`define PDR_OFS_J       8'h61
`define PDR_OFS_D_HIGH  8'h62
`define PDR_OFS_D_LOW   8'h63
`define PDR_OFS_R       8'h64
`define PDR_P_W         7
`define PDR_J_W         6
`define PDR_D_W         14
`define PDR_D_HIGH_W    6
`define PDR_R_W         4
`define PDR_D_MAX       14'h270F
`define PDR_J_ERR_CODE  6'h00
`define PDR_J_MIN       6'h01
`define PDR_J_MAX       6'h3f
`define PDR_D_MIN       14'h0000
`define PDR_RESET_BYTE  8'h00
`endif

/* pdr_pll_readback.v */
// pll divider readback registers: effective p, j, d and r monitors
// assumes reads arrive on a synchronous byte port; writes are accepted and dropped
// assumes both source sets are settled, synchronous levels
// the enable may switch at any edge; the next edge shows the new source
// d high and low are not captured together, so a changing d can tear
`include "pdr_defines.vh"
module pdr_pll_readback (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // pll configuration source selection
    input  wire        clk_auto_set_en,
    input  wire [6:0]  auto_p,
    input  wire [5:0]  auto_j,
    input  wire [13:0] auto_d,
    input  wire [3:0]  auto_r,
    input  wire [6:0]  prog_p,
    input  wire [5:0]  prog_j,
    input  wire [13:0] prog_d,
    input  wire [3:0]  prog_r,
    // register port
    input  wire        reg_rd,
    input  wire        reg_wr,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    // decoded status for the clock generator
    output reg         j_error,
    output reg         d_error
);
    // selected source, before the monitor flops
    reg  [6:0]  p_next;
    reg  [5:0]  j_next;
    reg  [13:0] d_next;
    reg  [3:0]  r_next;
    // monitor flops, one per field
    wire [6:0]  pll_prediv_monitor;
    wire [5:0]  pll_int_factor_monitor;
    wire [13:0] pll_frac_factor_monitor;
    wire [3:0]  pll_post_factor_monitor;
    // error decode of the selected source
    wire        j_bad;
    wire        d_bad;
    // read path
    wire        rd_take;
    wire [7:0]  img_p;
    wire [7:0]  img_j;
    wire [7:0]  img_d_high;
    wire [7:0]  img_d_low;
    wire [7:0]  img_r;
    reg  [7:0]  rdata_next;

    // source selection follows the enable level every cycle, no handover delay
    always @* begin
        if (clk_auto_set_en) begin
            p_next = auto_p;
            j_next = auto_j;
            d_next = auto_d;
            r_next = auto_r;
        end else begin
            p_next = prog_p;
            j_next = prog_j;
            d_next = prog_d;
            r_next = prog_r;
        end
    end

    // pre-divider code, n stands for n+1
    pdr_field_hold #(
        .W (`PDR_P_W)
    ) u_hold_p (
        .clk (clk),
        .rst (rst),
        .d   (p_next),
        .q   (pll_prediv_monitor)
    );

    // integer factor code, zero is an error
    pdr_field_hold #(
        .W (`PDR_J_W)
    ) u_hold_j (
        .clk (clk),
        .rst (rst),
        .d   (j_next),
        .q   (pll_int_factor_monitor)
    );

    // fractional digits, kept as one 14-bit value
    pdr_field_hold #(
        .W (`PDR_D_W)
    ) u_hold_d (
        .clk (clk),
        .rst (rst),
        .d   (d_next),
        .q   (pll_frac_factor_monitor)
    );

    // post factor code, n stands for n+1
    pdr_field_hold #(
        .W (`PDR_R_W)
    ) u_hold_r (
        .clk (clk),
        .rst (rst),
        .d   (r_next),
        .q   (pll_post_factor_monitor)
    );

    // j below one is the error code
    pdr_range_check #(
        .W  (`PDR_J_W),
        .LO (`PDR_J_MIN),
        .HI (`PDR_J_MAX)
    ) u_check_j (
        .val (j_next),
        .bad (j_bad)
    );

    // d is still reported raw when above the decimal limit
    pdr_range_check #(
        .W  (`PDR_D_W),
        .LO (`PDR_D_MIN),
        .HI (`PDR_D_MAX)
    ) u_check_d (
        .val (d_next),
        .bad (d_bad)
    );

    // flags share the monitor lag so from the first edge after reset they describe the current monitor flops, not the held reg_rdata byte
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            j_error <= 1'b0;
            d_error <= 1'b0;
        end else begin
            j_error <= j_bad;
            d_error <= d_bad;
        end
    end

    // byte images with reserved bits forced low
    assign img_p      = {1'b0, pll_prediv_monitor};
    assign img_j      = {2'b00, pll_int_factor_monitor};
    assign img_d_high = {2'b00, pll_frac_factor_monitor[13:8]};
    assign img_d_low  = pll_frac_factor_monitor[7:0];
    assign img_r      = {4'h0, pll_post_factor_monitor};
    // a read with the write strobe high is dropped as a whole
    assign rd_take    = reg_rd & ~reg_wr;

    // unmapped addresses and reserved bits read zero; writes never reach state
    always @* begin
        rdata_next = `PDR_RESET_BYTE;
        case (reg_addr)
            `PDR_OFS_P:      rdata_next = img_p;
            `PDR_OFS_J:      rdata_next = img_j;
            `PDR_OFS_D_HIGH: rdata_next = img_d_high;
            `PDR_OFS_D_LOW:  rdata_next = img_d_low;
            `PDR_OFS_R:      rdata_next = img_r;
            default:         rdata_next = `PDR_RESET_BYTE;
        endcase
    end

    // j.d times r is reported as raw fields; software forms the product
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= `PDR_RESET_BYTE;
        end else if (rd_take) begin
            reg_rdata <= rdata_next;
        end
    end

    // valid is a one-cycle pulse per accepted read
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= rd_take;
        end
    end
endmodule

// one monitor field: a reset-to-zero register that reloads every cycle
// assumes the source value is settled before each rising edge
module pdr_field_hold #(
    parameter W = 8
) (
    // clock and reset
    input  wire         clk,
    input  wire         rst,
    // selected source value
    input  wire [W-1:0] d,
    // monitored value
    output reg  [W-1:0] q
);
    // no write path exists, so software can never disturb q
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= {W{1'b0}};
        end else begin
            q <= d;
        end
    end
endmodule

// range decode: flags a code below lo or above hi
// assumes lo is not above hi; purely combinational
module pdr_range_check #(
    parameter         W  = 8,
    parameter [W-1:0] LO = {W{1'b0}},
    parameter [W-1:0] HI = {W{1'b1}}
) (
    // code under test
    input  wire [W-1:0] val,
    // out-of-range indication
    output wire         bad
);
    assign bad = (val < LO) | (val > HI);
endmodule

/* pdr_readback_monitor.sv */
// checker for the pll readback register port
// assumes a bind to the block's own ports
module pdr_readback_monitor(input wire logic clk, rst, reg_rd, reg_wr, reg_rvalid,
    input wire logic [7:0] reg_addr, reg_rdata);
default clocking @(posedge clk); endclocking
default disable iff (rst);
property p_rv; reg_rd && !reg_wr |=> reg_rvalid; endproperty
a_rv: assert property (p_rv) else $error("read not answered");
property p_wr; reg_wr || !reg_rd |=> !reg_rvalid; endproperty
a_wr: assert property (p_wr) else $error("answer without read");
property p_j; reg_rd && !reg_wr && reg_addr == 8'h61 |=> reg_rdata[7:6] == 2'b00; endproperty
a_j: assert property (p_j) else $error("j spare bits set");
property p_r; reg_rd && !reg_wr && reg_addr == 8'h64 |=> reg_rdata[7:4] == 4'h0; endproperty
a_r: assert property (p_r) else $error("r spare bits set");
property p_p; reg_rd && !reg_wr && reg_addr == 8'h60 |=> reg_rdata[7] == 1'b0; endproperty
a_p: assert property (p_p) else $error("p spare bit set");
property p_dh; reg_rd && !reg_wr && reg_addr == 8'h62 |=> reg_rdata[7:6] == 2'b00; endproperty
a_dh: assert property (p_dh) else $error("d high spare bits set");
endmodule
bind pdr_pll_readback pdr_readback_monitor u_mon(.clk(clk), .rst(rst), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_rdata(reg_rdata));

/* pdr_pll_readback_tb.sv */
// bench for the pll readback registers in both source modes
// assumes reads answer on the taken edge itself; the check samples at the next falling edge
module pdr_pll_readback_tb;
timeunit 1ns; timeprecision 1ps;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
logic clk = 0, rst = 1, sel = 1, rd = 0, wr = 0, rv, je, de;
logic [6:0] ap = 0, pp = 0; logic [5:0] aj = 0, pj = 0; logic [13:0] ad = 0, pd = 0;
logic [3:0] ar = 0, pr = 0; logic [7:0] adr = 0, wd = 0, rdt; int mismatches = 0, check_count = 0;
always #2.5 clk = ~clk;
pdr_pll_readback u_dut(.clk(clk), .rst(rst), .clk_auto_set_en(sel), .auto_p(ap), .auto_j(aj),
    .auto_d(ad), .auto_r(ar), .prog_p(pp), .prog_j(pj), .prog_d(pd), .prog_r(pr), .reg_rd(rd),
    .reg_wr(wr), .reg_addr(adr), .reg_wdata(wd), .reg_rdata(rdt), .reg_rvalid(rv),
    .j_error(je), .d_error(de));
task automatic rdc(input [7:0] a, input [7:0] e);
    @(negedge clk) begin rd = 1; adr = a; end
    @(negedge clk) rd = 0;
    `CHK({rv, rdt}, {1'b1, e})
endtask
task automatic rd5(input [6:0] p, input [5:0] j, input [13:0] d, input [3:0] r);
    rdc(8'h60, {1'b0, p});
    rdc(8'h61, {2'b00, j});
    rdc(8'h62, {2'b00, d[13:8]});
    rdc(8'h63, d[7:0]);
    rdc(8'h64, {4'h0, r});
endtask
task automatic t_auto;
    ap = 7'h7f; aj = 6'h00; ad = 14'h270f; ar = 4'hf; pp = 7'h05; pj = 6'h09; pd = 14'h2710;
    rd5(7'h7f, 6'h00, 14'h270f, 4'hf);
    `CHK({je, de}, 2'b10)
    $display("t_auto done");
endtask
task automatic t_prog;
    sel = 0;
    rd5(7'h05, 6'h09, 14'h2710, 4'h0);
    `CHK({je, de}, 2'b01)
    $display("t_prog done");
endtask
task automatic t_wr;
    @(negedge clk) begin wr = 1; rd = 1; adr = 8'h60; wd = 8'hff; end
    @(negedge clk) begin wr = 0; rd = 0; end
    `CHK(rv, 1'b0)
    rdc(8'h60, 8'h05);
    rdc(8'h65, 8'h00);
    $display("t_wr done");
endtask
task end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask
initial begin #2000; mismatches++; end_of_test; end
initial begin repeat (12) @(negedge clk); rst = 0; t_auto; t_prog; t_wr; end_of_test; end
endmodule
